// file: occ_pkg.sv
// Constants, types and register layout for the on-chip oscillator clock select block.
// Assumes a single 100 MHz system clock and word-aligned AXI4-Lite access.
// Notes on behaviour
// - Protect bit 0 set allows writes to the clock control register group.
// - Low-speed oscillator stop bit 4 at zero keeps the low-speed oscillator running.
// - High-speed divider field bits 2..0 picks the ratio; code 000 divides by 2.
// - High-speed enable bit 0 set to one turns the high-speed oscillator on.
// - High-speed select bit 1 set makes it the on-chip oscillator clock.
// - System clock select bit 2 set picks the on-chip oscillator clock.
// - CPU division bits 7..6 pick the CPU division; 00 means no division.
// - CPU select bit 6 at zero lets the two division bits take effect.
// - Timer standby bit 6 at zero puts the timer module in the active state.
package occ_pkg;

	localparam logic [7:0] OFS_CK0   = 8'h00;
	localparam logic [7:0] OFS_CK1   = 8'h04;
	localparam logic [7:0] OFS_HSC0  = 8'h08;
	localparam logic [7:0] OFS_HSDV  = 8'h0C;
	localparam logic [7:0] OFS_OSD   = 8'h10;
	localparam logic [7:0] OFS_WPRT  = 8'h14;
	localparam logic [7:0] OFS_STBY  = 8'h18;
	localparam logic [7:0] OFS_STAT  = 8'h1C;

	localparam int BIT_PROT     = 0;
	localparam int BIT_LSO_STOP = 4;
	localparam int BIT_CPU1_LO  = 6;
	localparam int BIT_CPU1_HI  = 7;
	localparam int BIT_CPU0     = 6;
	localparam int BIT_HS_EN    = 0;
	localparam int BIT_HS_SEL   = 1;
	localparam int BIT_SYS_SEL  = 2;
	localparam int BIT_TMR_SB   = 6;
	localparam int DIV_MSB      = 2;
	localparam int ST_HS_STABLE = 0;
	localparam int ST_LSO_RUN   = 1;
	localparam int ST_SYS_ONCHP = 2;

	localparam logic [7:0] RST_CK0   = 8'h40;
	localparam logic [7:0] RST_CK1   = 8'h00;
	localparam logic [7:0] RST_HSC0  = 8'h00;
	localparam logic [7:0] RST_HSDV  = 8'h00;
	localparam logic [7:0] RST_OSD   = 8'h00;
	localparam logic [7:0] RST_WPRT  = 8'h00;
	localparam logic [7:0] RST_STBY  = 8'h40;

	localparam logic [7:0] MASK_CK0  = 8'h40;
	localparam logic [7:0] MASK_CK1  = 8'hD0;
	localparam logic [7:0] MASK_HSC0 = 8'h03;
	localparam logic [7:0] MASK_HSDV = 8'h07;
	localparam logic [7:0] MASK_OSD  = 8'h04;
	localparam logic [7:0] MASK_WPRT = 8'h01;
	localparam logic [7:0] MASK_STBY = 8'h40;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int CLK_PERIOD_NS = 10;
	localparam int HS_START_NS   = 9000;
	localparam int HS_START_CYC  = (HS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [4:0] LSO_RATIO    = 5'h10;
	localparam logic [4:0] HS_RATIO_OFS = 5'h02;
	localparam logic [4:0] CPU_RATIO_D0 = 5'h08;

	typedef enum logic [1:0]
	{
		OSC_OFF  = 2'b00,
		OSC_WARM = 2'b01,
		OSC_RUN  = 2'b10
	} occ_osc_state_t;

endpackage : occ_pkg

// file: occ_div_if.sv
// Tick divider carrier: a source tick, a ratio and the divided tick.
// Assumes both ends share sys_clk_i.
`timescale 1ns/1ps
interface occ_div_if;
	logic       src;
	logic [4:0] ratio;
	logic       tick;

	modport ctl
	(
		output src,
		output ratio,
		input  tick
	);
	modport div
	(
		input  src,
		input  ratio,
		output tick
	);
endinterface : occ_div_if

// file: occ_tick_div.sv
// Divides a stream of source ticks by a ratio, one output pulse per ratio ticks.
// Assumes the ratio is at least one; a ratio change takes hold at the next count.
`timescale 1ns/1ps
module occ_tick_div
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	occ_div_if.div   d
);
	logic [4:0] cnt_q;
	logic       tick_q;

	// Comparing with >= lets a lowered ratio end the current period at once.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= 5'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= 1'b0;
			if (d.src)
			begin
				if (cnt_q >= 5'(d.ratio - 5'h01))
				begin
					cnt_q  <= 5'h00;
					tick_q <= 1'b1;
				end
				else
				begin
					cnt_q <= 5'(cnt_q + 5'h01);
				end
			end
		end
	end

	assign d.tick = tick_q;
endmodule : occ_tick_div

// file: occ_osc_start.sv
// High-speed oscillator start-up model: stable after a fixed warm-up while enabled.
// Assumes en_i comes from a register on the same clock.
`timescale 1ns/1ps
module occ_osc_start
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic en_i,
	output logic      stable_o
);
	occ_pkg::occ_osc_state_t state_q;
	logic [9:0]              cnt_q;
	logic                    stable_q;

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q  <= occ_pkg::OSC_OFF;
			cnt_q    <= 10'h000;
			stable_q <= 1'b0;
		end
		else if (!en_i)
		begin
			state_q  <= occ_pkg::OSC_OFF;
			cnt_q    <= 10'h000;
			stable_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				occ_pkg::OSC_OFF:
				begin
					state_q <= occ_pkg::OSC_WARM;
					cnt_q   <= 10'h000;
				end
				occ_pkg::OSC_WARM:
				begin
					if (cnt_q == 10'(occ_pkg::HS_START_CYC - 1))
					begin
						state_q  <= occ_pkg::OSC_RUN;
						stable_q <= 1'b1;
					end
					else
					begin
						cnt_q <= 10'(cnt_q + 10'h001);
					end
				end
				occ_pkg::OSC_RUN:
				begin
					stable_q <= 1'b1;
				end
				default:
				begin
					state_q  <= occ_pkg::OSC_OFF;
					stable_q <= 1'b0;
				end
			endcase
		end
	end

	assign stable_o = stable_q;
endmodule : occ_osc_start

// file: occ_clock_select.sv
// Clock source and division control with write-protected registers on AXI4-Lite.
// Assumes one 100 MHz clock; ext_clk_i is an asynchronous pin sampled as a level.
// Oscillators and clocks are modelled as tick pulses on sys_clk_i.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module occ_clock_select
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        ext_clk_i,
	output logic             lso_run_o,
	output logic             hso_run_o,
	output logic             hso_stable_o,
	output logic             sysclk_tick_o,
	output logic             cpu_tick_o,
	output logic             timer_active_o
);
	logic        awready_q;
	logic        wready_q;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [31:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [7:0]  ck0_q;
	logic [7:0]  ck1_q;
	logic [7:0]  hsc0_q;
	logic [7:0]  hsdv_q;
	logic [7:0]  osd_q;
	logic [7:0]  wprt_q;
	logic [7:0]  stby_q;
	logic        ext_s1_q;
	logic        ext_s2_q;
	logic        ext_s3_q;
	logic        lso_run_q;
	logic        sys_tick_q;
	logic        timer_act_q;
	logic        wr_fire;
	logic        wr_en;
	logic        ext_rise;
	logic        onchip_tick;
	logic        sys_tick;
	logic        hs_stable;
	logic [4:0]  cpu_ratio;

	occ_div_if lso_div ();
	occ_div_if hs_div ();
	occ_div_if cpu_div ();

	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] ofs);
		reg_hit = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
	endfunction : reg_hit

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a[31:5] == 27'h000_0000) && (a[1:0] == 2'h0);
	endfunction : mapped

	function automatic logic is_prot(input logic [31:0] a);
		is_prot = reg_hit(a, occ_pkg::OFS_CK0) || reg_hit(a, occ_pkg::OFS_CK1)
			|| reg_hit(a, occ_pkg::OFS_HSC0) || reg_hit(a, occ_pkg::OFS_HSDV)
			|| reg_hit(a, occ_pkg::OFS_OSD);
	endfunction : is_prot

	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_en   = wr_fire && wstrb_q[0] && mapped(waddr_q);

	// Write channel: address and data are taken in either order, answered once both are in.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			waddr_q   <= 32'h0000_0000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= occ_pkg::RESP_OKAY;
		end
		else
		begin
			if (awready_q && s_axi_awvalid_i)
			begin
				waddr_q   <= s_axi_awaddr_i;
				aw_hold_q <= 1'b1;
				awready_q <= 1'b0;
			end
			else if (!aw_hold_q && !bvalid_q)
			begin
				awready_q <= 1'b1;
			end
			if (wready_q && s_axi_wvalid_i)
			begin
				wdata_q  <= s_axi_wdata_i;
				wstrb_q  <= s_axi_wstrb_i;
				w_hold_q <= 1'b1;
				wready_q <= 1'b0;
			end
			else if (!w_hold_q && !bvalid_q)
			begin
				wready_q <= 1'b1;
			end
			if (wr_fire)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= mapped(waddr_q) ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready_i)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read channel: data are captured at the edge that takes the address.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= occ_pkg::RESP_OKAY;
		end
		else if (arready_q && s_axi_arvalid_i)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= mapped(s_axi_araddr_i) ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
			if (!mapped(s_axi_araddr_i))
				rdata_q <= 32'h0000_0000;
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_CK0))
				rdata_q <= {24'h00_0000, ck0_q};
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_CK1))
				rdata_q <= {24'h00_0000, ck1_q};
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_HSC0))
				rdata_q <= {24'h00_0000, hsc0_q};
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_HSDV))
				rdata_q <= {24'h00_0000, hsdv_q};
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_OSD))
				rdata_q <= {24'h00_0000, osd_q};
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_WPRT))
				rdata_q <= {24'h00_0000, wprt_q};
			else if (reg_hit(s_axi_araddr_i, occ_pkg::OFS_STBY))
				rdata_q <= {24'h00_0000, stby_q};
			else
				rdata_q <= {29'h000_0000, osd_q[occ_pkg::BIT_SYS_SEL], lso_run_q, hs_stable};
		end
		else if (rvalid_q && s_axi_rready_i)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
		else if (!rvalid_q)
		begin
			arready_q <= 1'b1;
		end
	end

	// Register file. Protected writes with the protect bit clear still answer OKAY.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ck0_q  <= occ_pkg::RST_CK0;
			ck1_q  <= occ_pkg::RST_CK1;
			hsc0_q <= occ_pkg::RST_HSC0;
			hsdv_q <= occ_pkg::RST_HSDV;
			osd_q  <= occ_pkg::RST_OSD;
			wprt_q <= occ_pkg::RST_WPRT;
			stby_q <= occ_pkg::RST_STBY;
		end
		else if (wr_en)
		begin
			if (is_prot(waddr_q) && wprt_q[occ_pkg::BIT_PROT])
			begin
				case (waddr_q[7:0])
					occ_pkg::OFS_CK0:  ck0_q  <= wdata_q[7:0] & occ_pkg::MASK_CK0;
					occ_pkg::OFS_CK1:  ck1_q  <= wdata_q[7:0] & occ_pkg::MASK_CK1;
					occ_pkg::OFS_HSC0: hsc0_q <= wdata_q[7:0] & occ_pkg::MASK_HSC0;
					occ_pkg::OFS_HSDV: hsdv_q <= wdata_q[7:0] & occ_pkg::MASK_HSDV;
					occ_pkg::OFS_OSD:  osd_q  <= wdata_q[7:0] & occ_pkg::MASK_OSD;
					default:           ck0_q  <= ck0_q;
				endcase
			end
			if (reg_hit(waddr_q, occ_pkg::OFS_WPRT))
				wprt_q <= wdata_q[7:0] & occ_pkg::MASK_WPRT;
			if (reg_hit(waddr_q, occ_pkg::OFS_STBY))
				stby_q <= wdata_q[7:0] & occ_pkg::MASK_STBY;
		end
	end

	// The first stage feeds only the second; edges are found between stages two and three.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= ext_clk_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign ext_rise = ext_s2_q && !ext_s3_q;

	// CPU ratio: select bit 6 set forces divide-by-8, otherwise bits 7..6 decide.
	always_comb
	begin
		if (ck0_q[occ_pkg::BIT_CPU0])
			cpu_ratio = occ_pkg::CPU_RATIO_D0;
		else
		begin
			case (ck1_q[occ_pkg::BIT_CPU1_HI:occ_pkg::BIT_CPU1_LO])
				2'h0:    cpu_ratio = 5'h01;
				2'h1:    cpu_ratio = 5'h02;
				2'h2:    cpu_ratio = 5'h04;
				default: cpu_ratio = 5'h10;
			endcase
		end
	end

	assign lso_div.src   = lso_run_q;
	assign lso_div.ratio = occ_pkg::LSO_RATIO;
	assign hs_div.src    = hs_stable;
	assign hs_div.ratio  = 5'({2'h0, hsdv_q[occ_pkg::DIV_MSB:0]} + occ_pkg::HS_RATIO_OFS);
	assign onchip_tick   = hsc0_q[occ_pkg::BIT_HS_SEL] ? hs_div.tick : lso_div.tick;
	assign sys_tick      = osd_q[occ_pkg::BIT_SYS_SEL] ? onchip_tick : ext_rise;
	assign cpu_div.src   = sys_tick;
	assign cpu_div.ratio = cpu_ratio;

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lso_run_q   <= 1'b0;
			sys_tick_q  <= 1'b0;
			timer_act_q <= 1'b0;
		end
		else
		begin
			lso_run_q   <= !ck1_q[occ_pkg::BIT_LSO_STOP];
			sys_tick_q  <= sys_tick;
			timer_act_q <= !stby_q[occ_pkg::BIT_TMR_SB];
		end
	end

	occ_tick_div u_lso_div
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d         (lso_div)
	);

	occ_tick_div u_hs_div
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d         (hs_div)
	);

	occ_tick_div u_cpu_div
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d         (cpu_div)
	);

	occ_osc_start u_hs_osc
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.en_i      (hsc0_q[occ_pkg::BIT_HS_EN]),
		.stable_o  (hs_stable)
	);

	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o  = wready_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign lso_run_o       = lso_run_q;
	assign hso_run_o       = hsc0_q[occ_pkg::BIT_HS_EN];
	assign hso_stable_o    = hs_stable;
	assign sysclk_tick_o   = sys_tick_q;
	assign cpu_tick_o      = cpu_div.tick;
	assign timer_active_o  = timer_act_q;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	prot_write_a: assert property (
		(wr_en && reg_hit(waddr_q, occ_pkg::OFS_CK1) && wprt_q[occ_pkg::BIT_PROT])
		|=> ck1_q == ($past(wdata_q[7:0]) & occ_pkg::MASK_CK1))
		else $error("enabled write to clock control one not stored");

	prot_block_a: assert property (
		(wr_fire && is_prot(waddr_q) && !wprt_q[occ_pkg::BIT_PROT])
		|=> $stable({ck0_q, ck1_q, hsc0_q, hsdv_q, osd_q}))
		else $error("protected register changed while protect bit clear");

	lso_start_a: assert property (
		(wr_en && reg_hit(waddr_q, occ_pkg::OFS_CK1) && wprt_q[occ_pkg::BIT_PROT]
		&& !wdata_q[occ_pkg::BIT_LSO_STOP]) |=> ##1 lso_run_o ##[1:16] lso_div.tick)
		else $error("low-speed oscillator not running after stop bit cleared");

	hs_div2_a: assert property (
		(hs_div.tick && hsdv_q[occ_pkg::DIV_MSB:0] == 3'h0 && hso_stable_o)
		##1 (hsdv_q[occ_pkg::DIV_MSB:0] == 3'h0 && hso_stable_o)
		|-> !hs_div.tick ##1 hs_div.tick)
		else $error("high-speed divide-by-2 period wrong");

	hs_warmup_a: assert property (
		$rose(hso_run_o) |-> (!hso_stable_o)[*8])
		else $error("high-speed oscillator stable too early");

	hs_off_a: assert property (
		!hso_run_o |=> !hso_stable_o)
		else $error("high-speed oscillator stable while disabled");

	hs_select_a: assert property (
		(hsc0_q[occ_pkg::BIT_HS_SEL] && osd_q[occ_pkg::BIT_SYS_SEL])
		|=> sysclk_tick_o == $past(hs_div.tick))
		else $error("system tick does not follow high-speed clock");

	sys_select_a: assert property (
		(!osd_q[occ_pkg::BIT_SYS_SEL] && !$past(ext_s2_q) && ext_s2_q)
		|=> sysclk_tick_o)
		else $error("system tick does not follow external clock");

	cpu_nodiv_a: assert property (
		(!ck0_q[occ_pkg::BIT_CPU0] && ck1_q[occ_pkg::BIT_CPU1_HI:occ_pkg::BIT_CPU1_LO] == 2'h0
		&& sys_tick) |=> cpu_tick_o && sysclk_tick_o)
		else $error("CPU tick missing with no division");

	cpu_sel0_a: assert property (
		(ck0_q[occ_pkg::BIT_CPU0] && cpu_tick_o) |=> !cpu_tick_o)
		else $error("CPU tick repeated while divide-by-8 selected");

	timer_wake_a: assert property (
		(wr_en && reg_hit(waddr_q, occ_pkg::OFS_STBY) && !wdata_q[occ_pkg::BIT_TMR_SB])
		|=> ##1 timer_active_o)
		else $error("timer not active after standby bit cleared");

	prot_blocked_c: cover property (wr_fire && is_prot(waddr_q) && !wprt_q[occ_pkg::BIT_PROT]);
	hs_stable_c:    cover property ($rose(hso_stable_o));
	hs_system_c:    cover property (osd_q[occ_pkg::BIT_SYS_SEL] && hsc0_q[occ_pkg::BIT_HS_SEL]
		&& cpu_tick_o);
endmodule : occ_clock_select

// file: occ_clock_select_tb.sv
// Self-checking bench for the clock select block, driving AXI4-Lite and the external pin.
// Assumes the design's own assertions run alongside; only one clock domain exists.
`timescale 1ns/1ps
module occ_clock_select_tb;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic [31:0] awaddr = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata  = 32'h0000_0000;
	logic [3:0]  wstrb  = 4'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [31:0] araddr = 32'h0000_0000;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        ext    = 1'b0;
	logic [2:0]  ext_cnt = 3'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        lso_run, hso_run, hso_stable, sys_tick, cpu_tick, timer_active;
	logic        sel_cpu = 1'b0;
	logic [3:0]  lane    = 4'h1;
	logic        sel_tick;
	int          n_errors = 0;
	int          check_count = 0;
	int          ratio [4] = '{1, 2, 4, 16};

	assign sel_tick = sel_cpu ? cpu_tick : sys_tick;

	occ_clock_select occ_clock_select_i
	(
		.sys_clk_i(clk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_clk_i(ext),
		.lso_run_o(lso_run), .hso_run_o(hso_run), .hso_stable_o(hso_stable),
		.sysclk_tick_o(sys_tick), .cpu_tick_o(cpu_tick), .timer_active_o(timer_active)
	);

	always #5 clk = ~clk;

	// The external pin runs free with a period of ten system clocks.
	always @(posedge clk)
	begin
		ext_cnt <= (ext_cnt == 3'h4) ? 3'h0 : ext_cnt + 3'h1;
		if (ext_cnt == 3'h4)
			ext <= ~ext;
	end

	task complete_run;
		$display("checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk

	task hang(input string name);
		n_errors++;
		$display("unexpected %s: expected answer, seen none", name);
		complete_run();
	endtask : hang

	// Ready is stable between edges, so seeing it at the falling edge means a handshake next.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w, b, aw_hit, w_hit, b_hit;
		logic [1:0] resp;
		@(posedge clk);
		awaddr <= {24'h00_0000, a};
		wdata <= d;
		wstrb <= lane;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		n = 0;
		while ((aw || w || b) && n < 200)
		begin
			@(negedge clk);
			aw_hit = aw && (awready === 1'b1);
			w_hit = w && (wready === 1'b1);
			b_hit = b && !aw && !w && (bvalid === 1'b1);
			resp = bresp;
			@(posedge clk);
			if (aw_hit)
			begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w_hit)
			begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
			if (b_hit)
			begin
				bready <= 1'b0;
				b = 1'b0;
			end
			n++;
		end
		if (n >= 200)
			hang("write response");
		chk("bresp", 32'(er), 32'(resp));
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		logic ar, hit;
		logic [31:0] data;
		logic [1:0] resp;
		@(posedge clk);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar = 1'b1;
		hit = 1'b0;
		n = 0;
		while (!hit && n < 200)
		begin
			@(negedge clk);
			hit = !ar && (rvalid === 1'b1);
			data = rdata;
			resp = rresp;
			if (ar && arready === 1'b1)
			begin
				@(posedge clk);
				arvalid <= 1'b0;
				ar = 1'b0;
			end
			else
				@(posedge clk);
			if (hit)
				rready <= 1'b0;
			n++;
		end
		if (n >= 200)
			hang("read response");
		chk("rdata", exp, data);
		chk("rresp", 32'(er), 32'(resp));
	endtask : rd

	// The first gap after a change may be partial, so the third gap is judged.
	task period(input logic cpu, input int exp);
		int n, gap;
		sel_cpu = cpu;
		n = 0;
		gap = 0;
		for (int k = 0; k < 3; k++)
		begin
			gap = 0;
			do
			begin
				@(negedge clk);
				gap++;
				n++;
			end
			while (sel_tick !== 1'b1 && n < 4000);
		end
		if (n >= 4000)
			hang("tick");
		chk(cpu ? "cpu period" : "sys period", 32'(exp), 32'(gap));
	endtask : period

	task settle;
		repeat (3) @(negedge clk);
	endtask : settle

	initial
	begin
		int n;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(occ_pkg::OFS_CK0, 32'(occ_pkg::RST_CK0), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_CK1, 32'(occ_pkg::RST_CK1), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_HSC0, 32'(occ_pkg::RST_HSC0), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_HSDV, 32'(occ_pkg::RST_HSDV), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_OSD, 32'(occ_pkg::RST_OSD), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_WPRT, 32'(occ_pkg::RST_WPRT), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_STBY, 32'(occ_pkg::RST_STBY), occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_STAT, 32'h0000_0002, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_CK1, 32'h0000_0010, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_HSC0, 32'h0000_0001, occ_pkg::RESP_OKAY);
		settle();
		rd(occ_pkg::OFS_CK1, 32'h0000_0000, occ_pkg::RESP_OKAY);
		chk("lso_run", 32'h0000_0001, 32'(lso_run));
		chk("hso_run", 32'h0000_0000, 32'(hso_run));
		wr(occ_pkg::OFS_WPRT, 32'hFFFF_FF01, occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_WPRT, 32'h0000_0001, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_CK1, 32'h0000_0010, occ_pkg::RESP_OKAY);
		settle();
		chk("lso_run", 32'h0000_0000, 32'(lso_run));
		wr(occ_pkg::OFS_CK1, 32'h0000_0000, occ_pkg::RESP_OKAY);
		settle();
		chk("lso_run", 32'h0000_0001, 32'(lso_run));
		wr(8'h20, 32'h0000_0001, occ_pkg::RESP_SLVERR);
		rd(8'h22, 32'h0000_0000, occ_pkg::RESP_SLVERR);
		wr(occ_pkg::OFS_HSDV, 32'h0000_00FB, occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_HSDV, 32'h0000_0003, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_HSC0, 32'h0000_0001, occ_pkg::RESP_OKAY);
		settle();
		chk("hso_run", 32'h0000_0001, 32'(hso_run));
		n = 0;
		while (hso_stable !== 1'b1 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 1000)
			hang("hso_stable");
		chk("hso_stable", 32'h0000_0001, 32'(hso_stable));
		wr(occ_pkg::OFS_HSC0, 32'h0000_0003, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_OSD, 32'h0000_0004, occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_STAT, 32'h0000_0007, occ_pkg::RESP_OKAY);
		period(1'b0, 5);
		wr(occ_pkg::OFS_HSDV, 32'h0000_0000, occ_pkg::RESP_OKAY);
		period(1'b0, 2);
		wr(occ_pkg::OFS_CK0, 32'h0000_0000, occ_pkg::RESP_OKAY);
		for (int i = 0; i < 4; i++)
		begin
			wr(occ_pkg::OFS_CK1, {24'h00_0000, 2'(i), 6'h00}, occ_pkg::RESP_OKAY);
			period(1'b1, 2 * ratio[i]);
		end
		wr(occ_pkg::OFS_CK1, 32'h0000_0000, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_CK0, 32'h0000_0040, occ_pkg::RESP_OKAY);
		period(1'b1, 16);
		wr(occ_pkg::OFS_OSD, 32'h0000_0000, occ_pkg::RESP_OKAY);
		period(1'b0, 10);
		wr(occ_pkg::OFS_STBY, 32'h0000_0000, occ_pkg::RESP_OKAY);
		settle();
		chk("timer_active", 32'h0000_0001, 32'(timer_active));
		wr(occ_pkg::OFS_STBY, 32'h0000_0040, occ_pkg::RESP_OKAY);
		settle();
		chk("timer_active", 32'h0000_0000, 32'(timer_active));
		// A write with the low byte lane off must leave the register alone.
		lane = 4'h0;
		wr(occ_pkg::OFS_STBY, 32'h0000_0000, occ_pkg::RESP_OKAY);
		lane = 4'h1;
		rd(occ_pkg::OFS_STBY, 32'h0000_0040, occ_pkg::RESP_OKAY);
		chk("timer_active", 32'h0000_0000, 32'(timer_active));
		wr(occ_pkg::OFS_WPRT, 32'h0000_0000, occ_pkg::RESP_OKAY);
		wr(occ_pkg::OFS_OSD, 32'h0000_0004, occ_pkg::RESP_OKAY);
		rd(occ_pkg::OFS_OSD, 32'h0000_0000, occ_pkg::RESP_OKAY);
		complete_run();
	end
endmodule : occ_clock_select_tb
